// ==== common/foc_pkg.sv ====
`default_nettype none
package foc_pkg;
  // request layout and vendor command set
  localparam logic [7:0] FOC_FN_VENDOR = 8'h30;
  localparam logic [7:0] FOC_CMD_SET_MODE = 8'h01;
  localparam logic [7:0] FOC_CMD_GET_MODE = 8'h30;
  localparam logic [7:0] FOC_CMD_SET_PWM = 8'h35;
  localparam logic [7:0] FOC_CMD_GET_PWM = 8'h36;
  localparam logic [3:0] FOC_LEN_SET_MODE = 4'h1;
  localparam logic [3:0] FOC_LEN_SET_PWM = 4'h2;
  localparam logic [3:0] FOC_LEN_GET = 4'h0;
  localparam logic [3:0] FOC_RLEN_MODE = 4'h1;
  localparam logic [3:0] FOC_RLEN_PWM = 4'h7;
  localparam logic FOC_MODE_STANDARD = 1'b0;
  localparam logic FOC_MODE_MANUAL = 1'b1;
  localparam int FOC_FAN_COUNT = 7;
  localparam logic [7:0] FOC_SEL_MAX = 8'h06;
  localparam logic [6:0] FOC_DUTY_FULL = 7'h64;
  localparam logic [7:0] FOC_DUTY_FULL_B = 8'h64;
  // completion codes
  localparam logic [7:0] FOC_CC_OK = 8'h00;
  localparam logic [7:0] FOC_CC_BAD_CMD = 8'hc1;
  localparam logic [7:0] FOC_CC_BAD_LEN = 8'hc7;
  localparam logic [7:0] FOC_CC_RANGE = 8'hc9;
  // register byte offsets
  localparam logic [7:0] FOC_OFF_REQ_HEAD = 8'h00;
  localparam logic [7:0] FOC_OFF_REQ_CTRL = 8'h04;
  localparam logic [7:0] FOC_OFF_STATUS = 8'h08;
  localparam logic [7:0] FOC_OFF_RESP_LO = 8'h0c;
  localparam logic [7:0] FOC_OFF_RESP_HI = 8'h10;
  // field positions
  localparam int FOC_CTRL_LEN_LSB = 0;
  localparam int FOC_CTRL_SRC_BIT = 8;
  localparam int FOC_STAT_LEN_LSB = 8;
  localparam int FOC_STAT_MODE_BIT = 16;
  localparam int FOC_STAT_SRC_BIT = 24;
  // reset values
  localparam logic FOC_MODE_RST = FOC_MODE_STANDARD;
  localparam logic [6:0] FOC_DUTY_RST = 7'h64;
  localparam logic [31:0] FOC_HEAD_RST = 32'h0000_0000;
  localparam logic [7:0] FOC_CC_RST = 8'h00;
  // timing
  localparam int FOC_CLK_HZ = 50000000;
  localparam int FOC_PWM_HZ = 25000;
  localparam int FOC_STEP_CYCLES = FOC_CLK_HZ / (FOC_PWM_HZ * 100);
  localparam logic [6:0] FOC_STEP_LAST = 7'(FOC_STEP_CYCLES - 1);
  localparam logic [6:0] FOC_POS_LAST = 7'd99;
endpackage
`default_nettype wire

// ==== hdl/foc_pwm_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module foc_pwm_chan
  import foc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step,
  input wire logic [6:0] duty,
  output var logic pwm_out
);
  logic [6:0] pos_reg;
  logic [6:0] duty_reg;

  // duty is taken only at period start so a change never cuts a pulse short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= 7'h00;
      duty_reg <= FOC_DUTY_RST;
    end else if (step) begin
      if (pos_reg == FOC_POS_LAST) begin
        pos_reg <= 7'h00;
        duty_reg <= duty;
      end else begin
        pos_reg <= pos_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (pos_reg < duty_reg);
    end
  end
endmodule
`default_nettype wire

// ==== hdl/foc_fan_cmd.sv ====
// What this block does
// - request is function, command, then data bytes
// - only vendor function code 0x30 accepted
// - set mode: one byte, 0 standard, 1 manual
// - get mode returns one byte, current mode
// - set PWM: selector byte then duty byte
// - selector 0 processor, 1-6 chassis fans
// - duty in percent, 0x64 full, proportional
// - get PWM returns seven duty bytes, processor first
// - local and remote requests behave identically
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module foc_fan_cmd
  import foc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output var logic hreadyout,
  output var logic [31:0] hrdata,
  output var logic hresp,
  input wire logic [6:0] auto_duty,
  output var logic manual_mode,
  output logic processor_cooler_pwm,
  output logic chassis_cooler_first_pwm,
  output logic chassis_cooler_second_pwm,
  output logic chassis_cooler_third_pwm,
  output logic chassis_cooler_fourth_pwm,
  output logic chassis_cooler_fifth_pwm,
  output logic chassis_cooler_sixth_pwm
);
  import foc_pkg::*;

  logic accept;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] dph_addr_reg;
  logic go;
  logic [31:0] head_reg;
  logic [8:0] ctrl_reg;
  logic [7:0] cc_reg;
  logic [3:0] rlen_reg;
  logic [55:0] resp_reg;
  logic src_reg;
  logic [6:0] manual_duty_reg [FOC_FAN_COUNT];
  logic [6:0] eff_duty [FOC_FAN_COUNT];
  logic [6:0] auto_clamp;
  logic [6:0] step_cnt_reg;
  logic step_reg;
  logic [6:0] pwm_vec;
  logic [7:0] req_fn, req_cmd, req_d0, req_d1;
  logic [3:0] req_len;
  logic [7:0] cc_next;
  logic [3:0] rlen_next;
  logic [55:0] resp_next;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: writes zero-wait, reads one wait state so status is current

  assign accept = hsel && htrans[1] && hready;
  assign go = wr_pend_reg && (dph_addr_reg == FOC_OFF_REQ_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend_reg <= accept && hwrite;
        rd_pend_reg <= accept && !hwrite;
        if (accept) begin
          dph_addr_reg <= haddr[7:0];
        end
      end else begin
        rd_pend_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dph_addr_reg)
      FOC_OFF_REQ_HEAD: rd_mux = head_reg;
      FOC_OFF_REQ_CTRL: rd_mux = {23'h000000, ctrl_reg};
      FOC_OFF_STATUS: begin
        rd_mux[7:0] = cc_reg;
        rd_mux[FOC_STAT_LEN_LSB +: 4] = rlen_reg;
        rd_mux[FOC_STAT_MODE_BIT] = manual_mode;
        rd_mux[FOC_STAT_SRC_BIT] = src_reg;
      end
      FOC_OFF_RESP_LO: rd_mux = resp_reg[31:0];
      FOC_OFF_RESP_HI: rd_mux = {8'h00, resp_reg[55:32]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  assign req_fn = head_reg[7:0];
  assign req_cmd = head_reg[15:8];
  assign req_d0 = head_reg[23:16];
  assign req_d1 = head_reg[31:24];
  assign req_len = hwdata[FOC_CTRL_LEN_LSB +: 4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_reg <= FOC_HEAD_RST;
    end else if (wr_pend_reg && dph_addr_reg == FOC_OFF_REQ_HEAD) begin
      head_reg <= hwdata;
    end
  end

  assign auto_clamp = (auto_duty > FOC_DUTY_FULL) ? FOC_DUTY_FULL : auto_duty;

  always_comb begin
    cc_next = FOC_CC_OK;
    rlen_next = 4'h0;
    resp_next = 56'h0;
    if (req_fn != FOC_FN_VENDOR) begin
      cc_next = FOC_CC_BAD_CMD;
    end else begin
      case (req_cmd)
        FOC_CMD_SET_MODE: begin
          if (req_len != FOC_LEN_SET_MODE) cc_next = FOC_CC_BAD_LEN;
          else if (req_d0 > 8'h01) cc_next = FOC_CC_RANGE;
        end
        FOC_CMD_GET_MODE: begin
          if (req_len != FOC_LEN_GET) begin
            cc_next = FOC_CC_BAD_LEN;
          end else begin
            rlen_next = FOC_RLEN_MODE;
            resp_next[7:0] = {7'h00, manual_mode};
          end
        end
        FOC_CMD_SET_PWM: begin
          if (req_len != FOC_LEN_SET_PWM) cc_next = FOC_CC_BAD_LEN;
          else if (req_d0 > FOC_SEL_MAX) cc_next = FOC_CC_RANGE;
          else if (req_d1 > FOC_DUTY_FULL_B) cc_next = FOC_CC_RANGE;
        end
        FOC_CMD_GET_PWM: begin
          if (req_len != FOC_LEN_GET) begin
            cc_next = FOC_CC_BAD_LEN;
          end else begin
            rlen_next = FOC_RLEN_PWM;
            for (int k = 0; k < FOC_FAN_COUNT; k++) begin
              resp_next[8*k +: 8] = {1'b0, eff_duty[k]};
            end
          end
        end
        default: cc_next = FOC_CC_BAD_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution; the source bit is only recorded, never steers behaviour

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 9'h000;
      cc_reg <= FOC_CC_RST;
      rlen_reg <= 4'h0;
      resp_reg <= 56'h0;
      src_reg <= 1'b0;
    end else if (go) begin
      ctrl_reg <= hwdata[8:0];
      cc_reg <= cc_next;
      rlen_reg <= rlen_next;
      resp_reg <= resp_next;
      src_reg <= hwdata[FOC_CTRL_SRC_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      manual_mode <= FOC_MODE_RST;
    end else if (go && cc_next == FOC_CC_OK && req_cmd == FOC_CMD_SET_MODE) begin
      manual_mode <= req_d0[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < FOC_FAN_COUNT; k++) manual_duty_reg[k] <= FOC_DUTY_RST;
    end else if (go && cc_next == FOC_CC_OK && req_cmd == FOC_CMD_SET_PWM) begin
      manual_duty_reg[req_d0[2:0]] <= req_d1[6:0];
    end
  end

  // standard mode drives every fan from the automatic duty
  always_comb begin
    for (int k = 0; k < FOC_FAN_COUNT; k++) begin
      eff_duty[k] = manual_mode ? manual_duty_reg[k] : auto_clamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm step prescaler and channels

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_cnt_reg <= 7'h00;
      step_reg <= 1'b0;
    end else begin
      step_reg <= (step_cnt_reg == FOC_STEP_LAST);
      step_cnt_reg <= (step_cnt_reg == FOC_STEP_LAST) ? 7'h00 : step_cnt_reg + 7'h01;
    end
  end

  for (genvar g = 0; g < FOC_FAN_COUNT; g++) begin : g_chan
    foc_pwm_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .step(step_reg),
      .duty(eff_duty[g]),
      .pwm_out(pwm_vec[g])
    );
  end

  assign processor_cooler_pwm = pwm_vec[0];
  assign chassis_cooler_first_pwm = pwm_vec[1];
  assign chassis_cooler_second_pwm = pwm_vec[2];
  assign chassis_cooler_third_pwm = pwm_vec[3];
  assign chassis_cooler_fourth_pwm = pwm_vec[4];
  assign chassis_cooler_fifth_pwm = pwm_vec[5];
  assign chassis_cooler_sixth_pwm = pwm_vec[6];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_len_counts_data: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_GET_MODE && req_len != 4'h0
    |=> cc_reg == FOC_CC_BAD_LEN && rlen_reg == 4'h0)
    else $error("get mode with data not rejected");
  a_fn_reject: assert property (
    go && req_fn != FOC_FN_VENDOR |=> cc_reg == FOC_CC_BAD_CMD && $stable(manual_mode))
    else $error("foreign function code not rejected");
  a_mode_set_manual: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_SET_MODE && req_len == 4'h1
    && req_d0 == 8'h01 |=> manual_mode ##1 manual_mode || go)
    else $error("manual mode not taken");
  a_mode_get_reply: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_GET_MODE && req_len == 4'h0
    |=> rlen_reg == 4'h1 && resp_reg[7:0] == {7'h00, $past(manual_mode)})
    else $error("get mode reply wrong");
  a_pwm_sel_store: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_SET_PWM && req_len == 4'h2
    && req_d0 == 8'h00 && req_d1 <= 8'h64 |=> manual_duty_reg[0] == $past(req_d1[6:0]))
    else $error("processor fan duty not stored");
  a_duty_range: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_SET_PWM && req_len == 4'h2
    && req_d0 <= 8'h06 && req_d1 > 8'h64 |=> cc_reg == FOC_CC_RANGE)
    else $error("duty above full not rejected");
  a_get_pwm_bytes: assert property (
    go && req_fn == FOC_FN_VENDOR && req_cmd == FOC_CMD_GET_PWM && req_len == 4'h0
    |=> rlen_reg == 4'h7 && resp_reg[55:48] == {1'b0, $past(eff_duty[6])}
    && resp_reg[7:0] == {1'b0, $past(eff_duty[0])})
    else $error("get pwm reply wrong");
  a_src_same: assert property (
    go |=> src_reg == $past(hwdata[8]) && cc_reg == $past(cc_next))
    else $error("source changed the outcome");
  a_auto_override: assert property (
    !manual_mode && auto_duty > 7'h64 |-> eff_duty[3] == 7'h64 && eff_duty[0] == 7'h64)
    else $error("standard mode does not override");
  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_manual_set: cover property (go && req_cmd == FOC_CMD_SET_MODE ##1 manual_mode);
  c_get_pwm: cover property (go && req_cmd == FOC_CMD_GET_PWM ##1 rlen_reg == 4'h7);
  c_error: cover property (go ##1 cc_reg == FOC_CC_RANGE);
endmodule
`default_nettype wire

// ==== verification/foc_console_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module foc_console_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h5a5a_a5a5;
  end

  ////////////////////////////////////////////////////////////////////////
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 32);
    if (hready !== 1'b1) begin
      tb_top.errors++;
      $display("ERROR bus_wait expected 1 seen %b", hready);
      tb_top.print_verdict();
    end
  endtask

  // one whole-word single transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? wd : ~hwdata;
    wait_ready();
    rdv = hrdata;
    // released data line no longer shows the last value
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import foc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, manual_mode, mode_exp;
  logic [31:0] haddr, hwdata, hrdata, rd, junk;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] auto_duty = 7'h00;
  wire [6:0] pwm;
  logic [7:0] duty [7];
  logic [7:0] ea;
  logic [31:0] seed = 32'h0000_0030;
  logic [31:0] bad_h [7] = '{32'h0001_0131, 32'h0000_3730, 32'h0000_3030, 32'h1001_3530,
                             32'h0002_0130, 32'h1007_3530, 32'h6501_3530};
  logic [3:0] bad_l [7] = '{4'h1, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2};
  logic [7:0] bad_c [7] = '{8'hc1, 8'hc1, 8'hc7, 8'hc7, 8'hc9, 8'hc9, 8'hc9};
  int errors = 0;
  int comparisons = 0;
  int hi [7];

  always #10 hclk = ~hclk;

  foc_console_model con_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  foc_fan_cmd foc_fan_cmd_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .auto_duty(auto_duty),
    .manual_mode(manual_mode), .processor_cooler_pwm(pwm[0]),
    .chassis_cooler_first_pwm(pwm[1]), .chassis_cooler_second_pwm(pwm[2]),
    .chassis_cooler_third_pwm(pwm[3]), .chassis_cooler_fourth_pwm(pwm[4]),
    .chassis_cooler_fifth_pwm(pwm[5]), .chassis_cooler_sixth_pwm(pwm[6]));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [7:0] clamp(input logic [6:0] a);
    return (a > 7'd100) ? 8'h64 : {1'b0, a};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // run one request, random source, then check the whole status word
  task automatic exec(input logic [31:0] head, input logic [3:0] len, input logic [7:0] cc,
                      input logic [3:0] rlen);
    seed = xs(seed);
    con_i.xfer(1'b1, 32'(FOC_OFF_REQ_HEAD), head, junk);
    con_i.xfer(1'b1, 32'(FOC_OFF_REQ_CTRL), {23'h0, seed[0], 4'h0, len}, junk);
    con_i.xfer(1'b0, 32'(FOC_OFF_STATUS), 32'h0, rd);
    chk("status", {7'h0, seed[0], 7'h0, mode_exp, 4'h0, rlen, cc}, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic read_pwm(input logic [7:0] e [7]);
    exec({16'h0, FOC_CMD_GET_PWM, FOC_FN_VENDOR}, 4'h0, FOC_CC_OK, 4'h7);
    con_i.xfer(1'b0, 32'(FOC_OFF_RESP_LO), 32'h0, rd);
    chk("resp_lo", {e[3], e[2], e[1], e[0]}, rd);
    con_i.xfer(1'b0, 32'(FOC_OFF_RESP_HI), 32'h0, rd);
    chk("resp_hi", {8'h0, e[6], e[5], e[4]}, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    mode_exp = 1'b0;
    con_i.xfer(1'b0, 32'(FOC_OFF_STATUS), 32'h0, rd);
    chk("status_rst", 32'h0, rd);
    chk("mode_rst", 32'h0, {31'h0, manual_mode});
    $display("test reset done");
    mode_exp = 1'b1;
    exec(32'h0001_0130, 4'h1, FOC_CC_OK, 4'h0);
    chk("manual_mode", 32'h1, {31'h0, manual_mode});
    exec(32'h0000_3030, 4'h0, FOC_CC_OK, 4'h1);
    con_i.xfer(1'b0, 32'(FOC_OFF_RESP_LO), 32'h0, rd);
    chk("get_mode", 32'h1, rd);
    $display("test mode done");
    for (int f = 0; f < 7; f++) begin
      seed = xs(seed);
      // processor fan moves off its reset duty so the store is visible
      duty[f] = (f == 0) ? 8'h63 : (f == 1) ? 8'h64 : (f == 6) ? 8'h00 : 8'(seed % 101);
      exec({duty[f], 8'(f), FOC_CMD_SET_PWM, FOC_FN_VENDOR}, 4'h2, FOC_CC_OK, 4'h0);
    end
    read_pwm(duty);
    $display("test set pwm done");
    repeat (2100) @(posedge hclk);
    hi = '{default: 0};
    repeat (2000) begin
      @(posedge hclk);
      for (int f = 0; f < 7; f++) hi[f] += pwm[f];
    end
    for (int f = 0; f < 7; f++) chk("pwm_high", 32'(duty[f]) * 32'd20, 32'(hi[f]));
    $display("test pwm wave done");
    for (int i = 0; i < 7; i++) exec(bad_h[i], bad_l[i], bad_c[i], 4'h0);
    chk("mode_kept", 32'h1, {31'h0, manual_mode});
    read_pwm(duty);
    $display("test refusals done");
    mode_exp = 1'b0;
    exec(32'h0000_0130, 4'h1, FOC_CC_OK, 4'h0);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      auto_duty <= (i == 0) ? 7'h7f : seed[6:0];
      ea = clamp((i == 0) ? 7'h7f : seed[6:0]);
      read_pwm('{ea, ea, ea, ea, ea, ea, ea});
    end
    $display("test standard mode done");
    print_verdict();
  end
endmodule
`default_nettype wire
